/* adctrb_if.sv */
// Result stream between the sequencer and the skid buffer
`timescale 1ns/10ps
`default_nettype none
interface adctrb_if;
   logic valid;
   logic ready;
   logic [9:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* adctrb_params.svh */
// Constants for the ADC trigger and result buffer block
// ==========================================================
// Contract
// - Software writing the go flag to one starts a conversion sequence.
// - Five trigger enables, one per source; any enabled source starts conversion.
// - Hardware trigger sets the go flag; completion clears it.
// - Nonzero acquisition time runs a sampling interval, then converts automatically.
// - Completion seen as go clearing, irq flag setting, or empty clearing.
// - Four-entry result buffer, addresses 0..3, active only when enabled.
// - Results written at write address, which then increments and wraps.
// - Buffer-empty flag shows whether any unread result is held.
// - Overflow flag sets when a result overwrites an unread location.
// - Two-bit read pointer gives next read address; it is read-only.
// - Irq level selects flag on every, every second or fourth write.
// - Read pointer clears to zero at the start of every sequence; code clears it only on a start from idle, not on continuous-loop repeats.
// - Right justified: low byte read advances; left justified: high byte.
// - Single-shot: at sequence end go clears and irq flag sets; code sets irq only on a buffer write.
// - Continuous loop repeats sequence, irq flag per irq level field.
`ifndef ADCTRB_PARAMS_SVH
`define ADCTRB_PARAMS_SVH
`define ADCTRB_NUM_TRIG 5
`define ADCTRB_DEPTH 4
`define ADCTRB_PTR_W 2
`define ADCTRB_RES_W 10
`define ADCTRB_IRQL_EVERY 2'h0
`define ADCTRB_IRQL_SECOND 2'h1
`define ADCTRB_IRQL_FOURTH 2'h2
`define ADCTRB_TRIG_RESET 5'h00
`define ADCTRB_CONV_BITS 12
`endif

/* adctrb_pkg.sv */
// Types for the ADC trigger and result buffer block
package adctrb_pkg;
   typedef enum logic [1:0] {
      ADCTRB_IDLE = 2'b00,
      ADCTRB_ACQ = 2'b01,
      ADCTRB_CONV = 2'b10
   } adctrb_state_t;
   typedef logic [15:0] adctrb_word_t;
endpackage

/* adctrb_skid.sv */
// Two-entry buffer in the result path
`timescale 1ns/10ps
`default_nettype none
module adctrb_skid
   import adctrb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   adctrb_if.snk in_s,
   output logic out_valid,
   input wire logic out_ready,
   output logic [9:0] out_data
);
   logic [9:0] mem_reg [2];
   logic rd_reg, wr_reg;
   logic [1:0] cnt_reg;
   wire push = in_s.valid && in_s.ready;
   wire pop = out_valid && out_ready;
   assign in_s.ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = mem_reg[rd_reg];
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else if (clk_en) begin
         if (push) wr_reg <= ~wr_reg;
         if (pop) rd_reg <= ~rd_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (clk_en && push) mem_reg[wr_reg] <= in_s.data;
   end
endmodule
`default_nettype wire

/* adctrb_top.sv */
// Trigger, acquisition sequencer and four-entry result buffer
`timescale 1ns/10ps
`default_nettype none
`include "adctrb_params.svh"
module adctrb_top
   import adctrb_pkg::*;
#(
   parameter int RES_W = `ADCTRB_RES_W
)(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic converter_on,
   input wire logic result_buffer_enable,
   input wire logic continuous_loop_select,
   input wire logic left_justify,
   input wire logic [4:0] trigger_source_enables,
   input wire logic [4:0] trigger_events,
   input wire logic [1:0] irq_level_select,
   input wire logic [3:0] acquisition_time,
   input wire logic bit_tick,
   input wire logic go_write,
   input wire logic go_write_value,
   input wire logic irq_flag_clear,
   input wire logic ovf_flag_clear,
   input wire logic read_low_byte,
   input wire logic read_high_byte,
   input wire logic core_done,
   input wire logic [9:0] core_result,
   output logic go_flag,
   output logic core_sample,
   output logic core_start,
   output logic conversion_irq_flag,
   output logic buffer_empty_flag,
   output logic buffer_overflow_flag,
   output logic [1:0] result_read_pointer,
   output logic [7:0] result_low_byte,
   output logic [7:0] result_high_byte
);
   if (RES_W != 10) begin : g_bad_res_w
      $error("RES_W must be 10");
   end
   // ==========================================================
   // Start and acquisition sequencing
   adctrb_state_t st_reg, st_next;
   logic [3:0] acq_reg;
   logic go_reg, start_reg, samp_reg;
   wire hw_trig = |(trigger_source_enables & trigger_events);
   wire sw_go = go_write && go_write_value;
   wire start_req = converter_on && (sw_go || hw_trig) &&
      (st_reg == ADCTRB_IDLE);
   wire abort = go_write && !go_write_value;
   wire acq_done = (acq_reg == 4'h0) || (bit_tick && acq_reg == 4'h1);
   adctrb_if link();
   wire res_taken = link.valid && link.ready;
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         ADCTRB_IDLE: if (start_req)
            st_next = (acquisition_time == 4'h0) ? ADCTRB_CONV : ADCTRB_ACQ;
         ADCTRB_ACQ: if (acq_done) st_next = ADCTRB_CONV;
         ADCTRB_CONV: if (res_taken && !continuous_loop_select)
            st_next = ADCTRB_IDLE;
         default: st_next = ADCTRB_IDLE;
      endcase
      if (abort || !converter_on) st_next = ADCTRB_IDLE;
   end
   wire conv_go = (st_next == ADCTRB_CONV) &&
      ((st_reg != ADCTRB_CONV) || res_taken);
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= ADCTRB_IDLE;
         acq_reg <= 4'h0;
         go_reg <= 1'b0;
         start_reg <= 1'b0;
         samp_reg <= 1'b0;
      end else if (clk_en) begin
         st_reg <= st_next;
         if (start_req) acq_reg <= acquisition_time;
         else if (bit_tick && acq_reg != 4'h0) acq_reg <= acq_reg - 4'h1;
         go_reg <= (st_next != ADCTRB_IDLE);
         start_reg <= conv_go;
         samp_reg <= (st_next == ADCTRB_ACQ);
      end
   end
   assign go_flag = go_reg;
   assign core_start = start_reg;
   assign core_sample = samp_reg;
   // Core result enters the skid buffer while converting
   logic cv_reg;
   logic [9:0] cd_reg;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cv_reg <= 1'b0;
         cd_reg <= 10'h000;
      end else if (clk_en) begin
         if (core_done && st_reg == ADCTRB_CONV) begin
            cv_reg <= 1'b1;
            cd_reg <= core_result;
         end else if (res_taken || st_reg != ADCTRB_CONV) cv_reg <= 1'b0;
      end
   end
   assign link.valid = cv_reg;
   assign link.data = cd_reg;
   logic bv;
   logic [9:0] bd;
   adctrb_skid u_skid (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .in_s(link),
      .out_valid(bv),
      .out_ready(1'b1),
      .out_data(bd)
   );
   // ==========================================================
   // Four-entry circular result buffer
   logic [9:0] buf_reg [`ADCTRB_DEPTH];
   logic [3:0] unread_reg;
   logic [1:0] wp_reg, rp_reg, wcnt_reg;
   logic irq_reg, ovf_reg, emp_reg;
   logic [7:0] lo_reg, hi_reg;
   wire wr = bv && result_buffer_enable;
   wire rd_adv = left_justify ? read_high_byte : read_low_byte;
   wire ovf_set = wr && unread_reg[wp_reg];
   wire [1:0] wcnt_n = wcnt_reg + 2'h1;
   wire lvl_hit = (irq_level_select == `ADCTRB_IRQL_EVERY) ||
      (irq_level_select == `ADCTRB_IRQL_SECOND && wcnt_n[0] == 1'b0) ||
      (wcnt_n == 2'h0);
   wire irq_set = wr && (continuous_loop_select ? lvl_hit :
      !continuous_loop_select);
   wire [9:0] cur = buf_reg[rp_reg];
   wire [15:0] just = left_justify ? {cur, 6'h00} : {6'h00, cur};
   wire [3:0] unread_next;
   wire [9:0] buf_next [`ADCTRB_DEPTH];
   genvar gi;
   generate
      for (gi = 0; gi < `ADCTRB_DEPTH; gi++) begin : g_ent
         wire hit_w = wr && (wp_reg == 2'(gi));
         wire hit_r = rd_adv && (rp_reg == 2'(gi));
         // A write to the entry wins over a read of it
         assign buf_next[gi] = hit_w ? bd : buf_reg[gi];
         assign unread_next[gi] = hit_w || (unread_reg[gi] && !hit_r);
      end
   endgenerate
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         buf_reg <= '{default: 10'h000};
         unread_reg <= 4'h0;
      end else if (clk_en) begin
         buf_reg <= buf_next;
         unread_reg <= unread_next;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wp_reg <= 2'h0;
         rp_reg <= 2'h0;
         wcnt_reg <= 2'h0;
         irq_reg <= 1'b0;
         ovf_reg <= 1'b0;
         emp_reg <= 1'b1;
         lo_reg <= 8'h00;
         hi_reg <= 8'h00;
      end else if (clk_en) begin
         if (start_req) begin
            rp_reg <= 2'h0;
            wp_reg <= 2'h0;
            wcnt_reg <= 2'h0;
         end else begin
            if (wr) wp_reg <= wp_reg + 2'h1;
            if (rd_adv) rp_reg <= rp_reg + 2'h1;
            if (wr) wcnt_reg <= wcnt_n;
         end
         if (irq_set) irq_reg <= 1'b1;
         else if (irq_flag_clear) irq_reg <= 1'b0;
         if (ovf_set) ovf_reg <= 1'b1;
         else if (ovf_flag_clear) ovf_reg <= 1'b0;
         // Empty once only the entry being read remains unread
         if (wr) emp_reg <= 1'b0;
         else if (rd_adv) emp_reg <= ((unread_reg &
            ~(4'h1 << rp_reg)) == 4'h0);
         lo_reg <= just[7:0];
         hi_reg <= just[15:8];
      end
   end
   assign conversion_irq_flag = irq_reg;
   assign buffer_overflow_flag = ovf_reg;
   assign buffer_empty_flag = emp_reg;
   assign result_read_pointer = rp_reg;
   assign result_low_byte = lo_reg;
   assign result_high_byte = hi_reg;
   // ==========================================================
   // Assertions
   a_go_from_trig: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && start_req |=> go_flag)
      else $error("go flag not set on start");
   a_ptr_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && start_req |=> result_read_pointer == 2'h0)
      else $error("read pointer not cleared on start");
   a_ptr_advance: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && !start_req && rd_adv |=>
      result_read_pointer == $past(result_read_pointer) + 2'h1)
      else $error("read pointer did not advance");
   a_ovf_set: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && ovf_set |=> buffer_overflow_flag)
      else $error("overflow not flagged");
   a_empty_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && wr |=> !buffer_empty_flag)
      else $error("empty flag not cleared on write");
   a_irq_every: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && wr && !continuous_loop_select |=> conversion_irq_flag)
      else $error("single shot irq missing");
   a_buf_off: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && !result_buffer_enable && !start_req |=>
      $stable(wp_reg))
      else $error("buffer written while disabled");
   a_acq_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
      clk_en && start_req && acquisition_time != 4'h0 |=>
      !core_start)
      else $error("conversion began before acquisition");
   c_hw_start: cover property (@(posedge ref_clk) hw_trig && start_req);
   c_overflow: cover property (@(posedge ref_clk) ovf_set);
   c_loop_irq: cover property (@(posedge ref_clk)
      irq_set && continuous_loop_select);
endmodule
`default_nettype wire

/* adctrb_top_tb.sv */
// Self-checking testbench for the trigger and result buffer block
`timescale 1ns/10ps
`default_nettype none
module adctrb_top_tb;
   import adctrb_pkg::*;
   // ==========================================================
   // Stimulus signals and bookkeeping
   logic ref_clk = 1'b0, resetn = 1'b0, converter_on = 1'b0;
   logic result_buffer_enable = 1'b0, continuous_loop_select = 1'b0;
   logic left_justify = 1'b0, bit_tick = 1'b0, go_write = 1'b0;
   logic go_write_value = 1'b0, irq_flag_clear = 1'b0;
   logic ovf_flag_clear = 1'b0, read_low_byte = 1'b0;
   logic read_high_byte = 1'b0, core_done = 1'b0;
   logic [4:0] trigger_source_enables = 5'h00, trigger_events = 5'h00;
   logic [1:0] irq_level_select = 2'h0;
   logic [3:0] acquisition_time = 4'h0;
   logic [9:0] core_result = 10'h000;
   logic go_flag, core_sample, core_start, conversion_irq_flag;
   logic buffer_empty_flag, buffer_overflow_flag;
   logic [1:0] result_read_pointer;
   logic [7:0] result_low_byte, result_high_byte;
   int mismatches = 0, checked = 0, cycles = 0, starts = 0, used = 0;
   int ticks = 0, t0, n;
   logic [9:0] v [0:4];
   logic [15:0] w;
   adctrb_top dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
      .converter_on(converter_on), .result_buffer_enable(result_buffer_enable),
      .continuous_loop_select(continuous_loop_select),
      .left_justify(left_justify),
      .trigger_source_enables(trigger_source_enables),
      .trigger_events(trigger_events), .irq_level_select(irq_level_select),
      .acquisition_time(acquisition_time), .bit_tick(bit_tick),
      .go_write(go_write), .go_write_value(go_write_value),
      .irq_flag_clear(irq_flag_clear), .ovf_flag_clear(ovf_flag_clear),
      .read_low_byte(read_low_byte), .read_high_byte(read_high_byte),
      .core_done(core_done), .core_result(core_result), .go_flag(go_flag),
      .core_sample(core_sample), .core_start(core_start),
      .conversion_irq_flag(conversion_irq_flag),
      .buffer_empty_flag(buffer_empty_flag),
      .buffer_overflow_flag(buffer_overflow_flag),
      .result_read_pointer(result_read_pointer),
      .result_low_byte(result_low_byte), .result_high_byte(result_high_byte));
   // ==========================================================
   // Clock, bit period ticks, start counter and hang guard
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      forever begin
         repeat (3) @(posedge ref_clk);
         #1 bit_tick = 1'b1;
         @(posedge ref_clk);
         #1 bit_tick = 1'b0;
      end
   end
   always @(posedge ref_clk) begin
      if (core_start === 1'b1) starts++;
      // Bit periods spent sampling, as the design sees them
      if (core_sample === 1'b1 && bit_tick === 1'b1) ticks++;
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end
   // ==========================================================
   // Helpers
   task automatic tick(int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic check(logic [15:0] seen, logic [15:0] exp, string msg);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg,
            seen, exp);
      end
   endtask
   function automatic logic [15:0] exp_word(logic [9:0] r, logic lj);
      return lj ? {r, 6'h00} : {6'h00, r};
   endfunction
   task automatic go_sw();
      go_write_value = 1'b1;
      pulse(go_write);
      go_write_value = 1'b0;
   endtask
   // Waits for the next start pulse, answers it and lets the write land
   task automatic convert(logic [9:0] r);
      int k;
      for (k = 0; k < 200 && starts <= used; k++) tick(1);
      used++;
      tick(2);
      core_result = r;
      pulse(core_done);
      tick(6);
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(94533));
      repeat (5) @(posedge ref_clk);
      #1 resetn = 1'b1;
      tick(1);
      check({go_flag, conversion_irq_flag, buffer_overflow_flag,
         result_read_pointer}, 16'h0000, "reset outputs");
      check(buffer_empty_flag, 1'b1, "reset empty");
      go_sw();
      tick(2);
      check(go_flag, 1'b0, "start while off");
      converter_on = 1'b1;
      result_buffer_enable = 1'b1;
      tick(1000);
      for (int i = 0; i < 5; i++) begin
         left_justify = i[0];
         tick(8);
         trigger_source_enables = 5'h01 << i;
         trigger_events = 5'h01 << ((i + 1) % 5);
         tick(1);
         trigger_events = 5'h00;
         tick(2);
         check(go_flag, 1'b0, "disabled source");
         trigger_events = 5'h01 << i;
         tick(1);
         trigger_events = 5'h00;
         tick(1);
         check(go_flag, 1'b1, "trigger sets go");
         check(result_read_pointer, 2'h0, "pointer at start");
         v[0] = $urandom();
         convert(v[0]);
         check(go_flag, 1'b0, "go cleared");
         check(conversion_irq_flag, 1'b1, "irq set");
         check(buffer_empty_flag, 1'b0, "empty cleared");
         w = exp_word(v[0], i[0]);
         check({result_high_byte, result_low_byte}, w, "result");
         if (i[0]) pulse(read_low_byte);
         else pulse(read_high_byte);
         tick(2);
         check(result_read_pointer, 2'h0, "other byte read");
         if (i[0]) pulse(read_high_byte);
         else pulse(read_low_byte);
         tick(2);
         check(result_read_pointer, 2'h1, "selected byte");
         check(buffer_empty_flag, 1'b1, "drained");
         pulse(irq_flag_clear);
      end
      trigger_source_enables = 5'h00;
      left_justify = 1'b0;
      result_buffer_enable = 1'b0;
      go_sw();
      convert(10'h2A5);
      check(buffer_empty_flag, 1'b1, "buffer disabled");
      result_buffer_enable = 1'b1;
      pulse(irq_flag_clear);
      acquisition_time = 4'h1 + ($urandom() % 6);
      t0 = ticks;
      go_sw();
      tick(1);
      check(go_flag, 1'b1, "software go");
      for (int k = 0; k < 300 && starts <= used; k++) tick(1);
      n = ticks - t0;
      check(n, acquisition_time, "acquisition length");
      used = starts - 1;
      convert(10'h155);
      check({result_high_byte, result_low_byte}, exp_word(10'h155, 1'b0),
         "acquired result");
      // Drain it so the loop run starts with no unread entry
      pulse(read_low_byte);
      acquisition_time = 4'h0;
      pulse(irq_flag_clear);
      pulse(ovf_flag_clear);
      continuous_loop_select = 1'b1;
      irq_level_select = $urandom() % 4;
      n = (irq_level_select == 2'h0) ? 1 : (irq_level_select == 2'h1) ? 2 : 4;
      go_sw();
      for (int k = 0; k < 5; k++) begin
         v[k] = $urandom();
         convert(v[k]);
         check(conversion_irq_flag, ((k + 1) % n) == 0,
            "irq level");
         check(buffer_overflow_flag, k == 4, "overflow");
         pulse(irq_flag_clear);
      end
      pulse(go_write);
      continuous_loop_select = 1'b0;
      tick(8);
      v[0] = v[4];
      for (int j = 0; j < 4; j++) begin
         check(result_low_byte, v[j][7:0], "entry low");
         pulse(read_low_byte);
         tick(2);
         check(result_read_pointer, (j + 1) % 4, "wrap");
      end
      check(buffer_empty_flag, 1'b1, "all read");
      end_of_test();
   end
endmodule
`default_nettype wire
